// ===== pkg/spf_map.svh
// register offsets, field positions, reset values and fixed counts of the serial port
`ifndef SPF_MAP_SVH
`define SPF_MAP_SVH

`define SPF_OFF_STAT      2'h0
`define SPF_OFF_CON1      2'h1
`define SPF_OFF_CON2      2'h2
`define SPF_OFF_BUF       2'h3
`define SPF_RESET_VAL     16'h0000
`define SPF_STAT_WMASK    16'hA01C
`define SPF_CON1_WMASK    16'h1FFF
`define SPF_CON2_WMASK    16'hE003

`define SPF_STAT_EN       15
`define SPF_STAT_IDLE     13
`define SPF_STAT_BEC_HI   10
`define SPF_STAT_BEC_LO   8
`define SPF_STAT_SHIFT_EMPTY_FLAG    7
`define SPF_STAT_ROV      6
`define SPF_STAT_RXE      5
`define SPF_STAT_IM_HI    4
`define SPF_STAT_IM_LO    2
`define SPF_STAT_TBF      1
`define SPF_STAT_RBF      0

`define SPF_C1_CLOCK_PIN_DISABLE     12
`define SPF_C1_DATA_OUT_DISABLE     11
`define SPF_C1_W16        10
`define SPF_C1_SMP        9
`define SPF_C1_CKE        8
`define SPF_C1_SLAVE_SELECT_ENABLE       7
`define SPF_C1_CKP        6
`define SPF_C1_MST        5
`define SPF_C1_SEC_HI     4
`define SPF_C1_SEC_LO     2
`define SPF_C1_PRI_HI     1
`define SPF_C1_PRI_LO     0

`define SPF_C2_FRM        15
`define SPF_C2_FSD        14
`define SPF_C2_FPOL       13
`define SPF_C2_FE         1
`define SPF_C2_ENH        0

`define SPF_FIFO_DEPTH    4'h8
`define SPF_FIFO_ONE      4'h1
`define SPF_FIFO_3Q       4'h6
`define SPF_HALF16        6'h20
`define SPF_HALF8         6'h10
`define SPF_LAST16        5'h0F
`define SPF_LAST8         5'h07
`define SPF_PRE_TICKS     6'h02
`define SPF_SEC_BASE      4'h8

`endif

// ===== pkg/spf_pkg.sv
// types shared by the serial port design
package spf_pkg;
	typedef struct packed {
		logic       en;
		logic       idle_stop;
		logic [2:0] imode;
		logic       clock_pin_disable;
		logic       data_out_disable;
		logic       w16;
		logic       sample_phase;
		logic       cke;
		logic       slave_select_enable;
		logic       clock_polarity;
		logic       master;
		logic [2:0] sec;
		logic [1:0] pri;
		logic       frm;
		logic       fsd;
		logic       fpol;
		logic       fe;
		logic       enh;
	} spf_cfg_type;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_PRE   = 4'b0010,
		ST_SHIFT = 4'b0100,
		ST_SLAVE = 4'b1000
	} spf_state_type;
endpackage : spf_pkg

// ===== rtl/spf_port.sv
// serial port with wishbone registers, eight-entry fifos and framed operation
//
// The implementer's own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "spf_map.svh"

module spf_fifo (
	// clock and clear
	input  wire logic        clk_i,
	input  wire logic        clr_i,
	// mode
	input  wire logic        deep_i,
	// write and read side
	input  wire logic        push_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        pop_i,
	output logic      [15:0] rdata_o,
	output logic      [3:0]  count_o,
	output logic             full_o,
	output logic             empty_o
);
	logic [15:0] mem_q [8];
	logic [2:0]  wr_q;
	logic [2:0]  rd_q;
	logic        do_push;
	logic        do_pop;

	// eight slots when deep, one slot in single-buffer mode
	assign full_o  = (count_o == (deep_i ? `SPF_FIFO_DEPTH : `SPF_FIFO_ONE));
	assign empty_o = (count_o == 4'h0);
	assign rdata_o = mem_q[rd_q];
	assign do_push = push_i && !full_o;
	assign do_pop  = pop_i && !empty_o;

	always_ff @(posedge clk_i) begin
		if (clr_i) begin
			wr_q    <= 3'h0;
			rd_q    <= 3'h0;
			count_o <= 4'h0;
		end else begin
			if (do_push) begin
				wr_q <= wr_q + 3'h1;
			end
			if (do_pop) begin
				rd_q <= rd_q + 3'h1;
			end
			count_o <= count_o + {3'h0, do_push} - {3'h0, do_pop};
		end
	end

	always_ff @(posedge clk_i) begin
		if (do_push) begin
			mem_q[wr_q] <= wdata_i;
		end
	end
endmodule : spf_fifo

module spf_port (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// device state
	input  wire logic        idle_mode_i,
	output logic             buf_cond_o,
	// serial clock pin
	input  wire logic        sck_i,
	output logic             sck_o,
	output logic             sck_oe_o,
	// serial data pins
	input  wire logic        sdi_i,
	output logic             sdo_o,
	output logic             sdo_oe_o,
	// select or frame pin
	input  wire logic        ss_i,
	output logic             ss_o,
	output logic             ss_oe_o
);
	spf_pkg::spf_cfg_type   cfg;
	spf_pkg::spf_state_type st_q;
	logic [15:0] stat_q, con1_q, con2_q;
	logic        rov_q;
	logic        req, wr, rd;
	logic [15:0] wmask, wdat, rd_mux;
	logic [15:0] tx_rdata, rx_rdata, rx_word;
	logic [3:0]  tx_cnt, rx_cnt;
	logic        tx_full, tx_empty, rx_full, rx_empty;
	logic        tx_push, tx_pop, rx_push, rx_pop, rx_drop;
	logic        run, clr, busy, done;
	logic [15:0] sh_tx_q, sh_rx_q;
	logic [5:0]  k_q, k_nx, half;
	logic [4:0]  bits_q, last;
	logic [9:0]  div_n, div_q;
	logic [6:0]  pri_n;
	logic [3:0]  sec_n;
	logic        tick, sck_q, cke_e, fs_d, fs_q, loaded_q, cond_d;
	logic        sck_s1, sck_s2, sck_s3, sdi_s1, sdi_s2, ss_s1, ss_s2;
	logic        lead, trail, selected, sync_in, smp_ev, out_ev;

	assign cfg = '{en: stat_q[`SPF_STAT_EN], idle_stop: stat_q[`SPF_STAT_IDLE],
		imode: stat_q[`SPF_STAT_IM_HI:`SPF_STAT_IM_LO],
		clock_pin_disable: con1_q[`SPF_C1_CLOCK_PIN_DISABLE], data_out_disable: con1_q[`SPF_C1_DATA_OUT_DISABLE], w16: con1_q[`SPF_C1_W16],
		sample_phase: con1_q[`SPF_C1_SMP], cke: con1_q[`SPF_C1_CKE], slave_select_enable: con1_q[`SPF_C1_SLAVE_SELECT_ENABLE],
		clock_polarity: con1_q[`SPF_C1_CKP], master: con1_q[`SPF_C1_MST],
		sec: con1_q[`SPF_C1_SEC_HI:`SPF_C1_SEC_LO], pri: con1_q[`SPF_C1_PRI_HI:`SPF_C1_PRI_LO],
		frm: con2_q[`SPF_C2_FRM], fsd: con2_q[`SPF_C2_FSD], fpol: con2_q[`SPF_C2_FPOL],
		fe: con2_q[`SPF_C2_FE], enh: con2_q[`SPF_C2_ENH]};

	// bus access: one wait state, every address answers
	assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr    = req && wb_we_i;
	assign rd    = req && !wb_we_i;
	assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wdat  = wb_dat_i[15:0];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= rd ? {16'h0000, rd_mux} : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stat_q <= `SPF_RESET_VAL;
			con1_q <= `SPF_RESET_VAL;
			con2_q <= `SPF_RESET_VAL;
		end else if (wr) begin
			unique case (wb_adr_i[3:2])
				`SPF_OFF_STAT: stat_q <= (stat_q & ~(wmask & `SPF_STAT_WMASK)) | (wdat & wmask & `SPF_STAT_WMASK);
				`SPF_OFF_CON1: con1_q <= (con1_q & ~(wmask & `SPF_CON1_WMASK)) | (wdat & wmask & `SPF_CON1_WMASK);
				`SPF_OFF_CON2: con2_q <= (con2_q & ~(wmask & `SPF_CON2_WMASK)) | (wdat & wmask & `SPF_CON2_WMASK);
				`SPF_OFF_BUF:  ;
			endcase
		end
	end

	// overflow flag: hardware set beats a software clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i || !cfg.en) begin
			rov_q <= 1'b0;
		end else if (rx_drop) begin
			rov_q <= 1'b1;
		end else if (wr && wb_adr_i[3:2] == `SPF_OFF_STAT && wb_sel_i[0] && !wdat[`SPF_STAT_ROV]) begin
			rov_q <= 1'b0;
		end
	end

	always_comb begin
		rd_mux = 16'h0000;
		unique case (wb_adr_i[3:2])
			`SPF_OFF_STAT: begin
				rd_mux = stat_q & `SPF_STAT_WMASK;
				if (cfg.enh) begin
					rd_mux[`SPF_STAT_BEC_HI:`SPF_STAT_BEC_LO] = cfg.master ? tx_cnt[2:0] : rx_cnt[2:0];
					rd_mux[`SPF_STAT_SHIFT_EMPTY_FLAG] = !busy;
					rd_mux[`SPF_STAT_RXE]   = rx_empty;
				end
				rd_mux[`SPF_STAT_ROV] = rov_q;
				rd_mux[`SPF_STAT_TBF] = tx_full;
				rd_mux[`SPF_STAT_RBF] = rx_full;
			end
			`SPF_OFF_CON1: rd_mux = con1_q;
			`SPF_OFF_CON2: rd_mux = con2_q;
			`SPF_OFF_BUF:  rd_mux = rx_rdata;
		endcase
	end

	// buffer address: write loads transmit side, read takes the oldest received word
	assign tx_push = wr && wb_adr_i[3:2] == `SPF_OFF_BUF && (wb_sel_i[1:0] != 2'h0) && cfg.en;
	assign rx_pop  = rd && wb_adr_i[3:2] == `SPF_OFF_BUF;
	assign clr     = rst_i || !cfg.en;
	assign rx_drop = done && rx_full;
	assign rx_push = done && !rx_full;
	assign rx_word = cfg.w16 ? sh_rx_q : {8'h00, sh_rx_q[7:0]};

	spf_fifo u_tx (
		.clk_i   (clk_i),
		.clr_i   (clr),
		.deep_i  (cfg.enh),
		.push_i  (tx_push),
		.wdata_i (wdat),
		.pop_i   (tx_pop),
		.rdata_o (tx_rdata),
		.count_o (tx_cnt),
		.full_o  (tx_full),
		.empty_o (tx_empty)
	);

	spf_fifo u_rx (
		.clk_i   (clk_i),
		.clr_i   (clr),
		.deep_i  (cfg.enh),
		.push_i  (rx_push),
		.wdata_i (rx_word),
		.pop_i   (rx_pop),
		.rdata_o (rx_rdata),
		.count_o (rx_cnt),
		.full_o  (rx_full),
		.empty_o (rx_empty)
	);

	// pin synchronisers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{sck_s1, sck_s2, sck_s3} <= 3'h0;
			{sdi_s1, sdi_s2}         <= 2'h0;
			{ss_s1, ss_s2}           <= 2'h3;
		end else begin
			{sck_s1, sck_s2, sck_s3} <= {sck_i, sck_s1, sck_s2};
			{sdi_s1, sdi_s2}         <= {sdi_i, sdi_s1};
			{ss_s1, ss_s2}           <= {ss_i, ss_s1};
		end
	end

	// prescaler: one half clock period per count of instruction cycles
	always_comb begin
		unique case (cfg.pri)
			2'h3: pri_n = 7'h01;
			2'h2: pri_n = 7'h04;
			2'h1: pri_n = 7'h10;
			2'h0: pri_n = 7'h40;
		endcase
		sec_n = `SPF_SEC_BASE - {1'b0, cfg.sec};
	end
	assign div_n = 10'(pri_n * sec_n);
	assign tick  = (div_q == div_n - 10'h001);

	always_ff @(posedge clk_i) begin
		if (rst_i || st_q == spf_pkg::ST_IDLE || st_q == spf_pkg::ST_SLAVE || tick) begin
			div_q <= 10'h000;
		end else if (run) begin
			div_q <= div_q + 10'h001;
		end
	end

	assign run      = cfg.en && !(cfg.idle_stop && idle_mode_i);
	assign cke_e    = cfg.cke && !cfg.frm;
	assign half     = cfg.w16 ? `SPF_HALF16 : `SPF_HALF8;
	assign last     = cfg.w16 ? `SPF_LAST16 : `SPF_LAST8;
	assign k_nx     = k_q + 6'h01;
	assign sync_in  = (ss_s2 == cfg.fpol);
	assign lead     = (sck_s2 != sck_s3) && (sck_s2 != cfg.clock_polarity);
	assign trail    = (sck_s2 != sck_s3) && (sck_s2 == cfg.clock_polarity);
	assign selected = cfg.frm || !cfg.slave_select_enable || !ss_s2;
	assign busy     = (st_q == spf_pkg::ST_PRE) || (st_q == spf_pkg::ST_SHIFT) || loaded_q || bits_q != 5'h00;

	// master sample: odd ticks when edge and phase differ, else even ticks
	assign smp_ev = (cke_e ^ cfg.sample_phase) ? (k_nx[0] && (cke_e ? k_nx < half : k_nx > 6'h01))
		: (!k_nx[0] && k_nx <= half);
	assign out_ev = cke_e ? (!k_nx[0] && k_nx < half) : (k_nx[0] && k_nx > 6'h01 && k_nx < half);

	assign tx_pop = (st_q == spf_pkg::ST_IDLE && run && cfg.master && !tx_empty && (!cfg.frm || !cfg.fsd || sync_in))
		|| (st_q == spf_pkg::ST_SLAVE && run && !loaded_q && bits_q == 5'h00 && !tx_empty);
	assign done   = (st_q == spf_pkg::ST_SHIFT && run && tick && k_nx == half + 6'h01)
		|| (st_q == spf_pkg::ST_SLAVE && run && selected && (cke_e ? lead : trail) && bits_q == last);

	always_ff @(posedge clk_i) begin
		if (clr) begin
			st_q     <= spf_pkg::ST_IDLE;
			k_q      <= 6'h00;
			bits_q   <= 5'h00;
			loaded_q <= 1'b0;
			sck_q    <= 1'b0;
			sh_tx_q  <= 16'h0000;
			sh_rx_q  <= 16'h0000;
		end else if (run) begin
			unique case (st_q)
				spf_pkg::ST_IDLE: begin
					sck_q <= cfg.clock_polarity;
					k_q   <= 6'h00;
					if (!cfg.master) begin
						st_q <= spf_pkg::ST_SLAVE;
					end else if (tx_pop) begin
						sh_tx_q <= cfg.w16 ? tx_rdata : {tx_rdata[7:0], 8'h00};
						st_q    <= (cfg.frm && !cfg.fsd && !cfg.fe) ? spf_pkg::ST_PRE : spf_pkg::ST_SHIFT;
					end
				end
				spf_pkg::ST_PRE: begin
					if (tick) begin
						sck_q <= !sck_q;
						k_q   <= (k_nx == `SPF_PRE_TICKS) ? 6'h00 : k_nx;
						if (k_nx == `SPF_PRE_TICKS) begin
							st_q <= spf_pkg::ST_SHIFT;
						end
					end
				end
				spf_pkg::ST_SHIFT: begin
					if (tick) begin
						k_q <= k_nx;
						if (k_nx <= half) begin
							sck_q <= !sck_q;
						end
						if (smp_ev) begin
							sh_rx_q <= {sh_rx_q[14:0], sdi_s2};
						end
						if (out_ev) begin
							sh_tx_q <= {sh_tx_q[14:0], 1'b0};
						end
						if (k_nx == half + 6'h01) begin
							st_q <= spf_pkg::ST_IDLE;
						end
					end
				end
				spf_pkg::ST_SLAVE: begin
					sck_q <= cfg.clock_polarity;
					if (cfg.master) begin
						st_q     <= spf_pkg::ST_IDLE;
						bits_q   <= 5'h00;
						loaded_q <= 1'b0;
					end else if (!selected || (cfg.frm && cfg.fsd && sync_in && bits_q == 5'h00 && !lead && !trail)) begin
						bits_q <= 5'h00;
					end else begin
						if (tx_pop) begin
							sh_tx_q  <= cfg.w16 ? tx_rdata : {tx_rdata[7:0], 8'h00};
							loaded_q <= 1'b1;
						end
						if (cke_e ? lead : trail) begin
							sh_rx_q  <= {sh_rx_q[14:0], sdi_s2};
							bits_q   <= (bits_q == last) ? 5'h00 : bits_q + 5'h01;
							if (bits_q == last) begin
								loaded_q <= 1'b0;
							end
						end
						if ((cke_e ? trail : lead) && (cke_e || bits_q != 5'h00)) begin
							sh_tx_q <= {sh_tx_q[14:0], 1'b0};
						end
					end
				end
			endcase
		end
	end

	// frame pulse: one bit clock before the data, or with the first bit clock
	always_comb begin
		fs_d = 1'b0;
		if (cfg.frm && !cfg.fsd) begin
			if (st_q == spf_pkg::ST_PRE) begin
				fs_d = 1'b1;
			end else if (st_q == spf_pkg::ST_SHIFT) begin
				fs_d = cfg.fe && k_q < `SPF_PRE_TICKS;
			end else if (st_q == spf_pkg::ST_SLAVE) begin
				fs_d = loaded_q && bits_q == 5'h00;
			end
		end
	end

	// buffer condition selected by the mode field
	always_comb begin
		unique case (cfg.imode)
			3'h7: cond_d = tx_full;
			3'h6: cond_d = tx_empty && busy;
			3'h5: cond_d = tx_empty && !busy;
			3'h4: cond_d = !tx_full;
			3'h3: cond_d = rx_full;
			3'h2: cond_d = rx_cnt >= `SPF_FIFO_3Q;
			3'h1: cond_d = !rx_empty;
			3'h0: cond_d = rx_empty;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fs_q       <= 1'b0;
			buf_cond_o <= 1'b0;
		end else begin
			fs_q       <= fs_d;
			buf_cond_o <= cfg.en && (cfg.enh ? cond_d : done);
		end
	end

	// pin drive
	assign sck_o    = sck_q;
	assign sck_oe_o = cfg.en && cfg.master && !cfg.clock_pin_disable;
	assign sdo_o    = sh_tx_q[15];
	assign sdo_oe_o = cfg.en && !cfg.data_out_disable && (cfg.master || selected);
	assign ss_o     = cfg.fpol ? fs_q : !fs_q;
	assign ss_oe_o  = cfg.en && cfg.frm && !cfg.fsd;
endmodule : spf_port

// ===== dv/spf_port_checker.sv
// assertions on the serial port bus and pins, bound to every port instance
`timescale 1ns/1ps
`include "spf_map.svh"
module spf_port_checker (
	// clock, reset and bus
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [3:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// device state and pins
	input wire logic        idle_mode_i,
	input wire logic        buf_cond_o,
	input wire logic        sck_i,
	input wire logic        sck_o,
	input wire logic        sck_oe_o,
	input wire logic        sdi_i,
	input wire logic        sdo_o,
	input wire logic        sdo_oe_o,
	input wire logic        ss_i,
	input wire logic        ss_o,
	input wire logic        ss_oe_o
);
	logic [15:0] c1_q;
	logic        en_q;
	logic        enh_q;
	logic        sck_q;
	logic [10:0] gap_q;
	logic [9:0]  quiet_q;
	logic        wr;
	logic        moved;
	logic [10:0] div;
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	assign moved = sck_o != sck_q;
	assign div = 11'((11'h001 << {~c1_q[1:0], 1'b0}) * (11'h008 - {8'h00, c1_q[4:2]}));
	// shadow of the configuration that the pins depend on
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			c1_q <= 16'h0000;
			en_q <= 1'b0;
			enh_q <= 1'b0;
		end else if (wr) begin
			if (wb_adr_i[3:2] == `SPF_OFF_CON1 && wb_sel_i[0]) c1_q[7:0] <= wb_dat_i[7:0];
			if (wb_adr_i[3:2] == `SPF_OFF_CON1 && wb_sel_i[1]) c1_q[15:8] <= wb_dat_i[15:8];
			if (wb_adr_i[3:2] == `SPF_OFF_STAT && wb_sel_i[1]) en_q <= wb_dat_i[15];
			if (wb_adr_i[3:2] == `SPF_OFF_CON2 && wb_sel_i[0]) enh_q <= wb_dat_i[0];
		end
	end
	// cycles since the clock pin last moved; quiet also restarts on bus writes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sck_q <= 1'b0;
			gap_q <= 11'h7FF;
			quiet_q <= 10'h000;
		end else begin
			sck_q <= sck_o;
			gap_q <= moved ? 11'h001 : gap_q + {10'h000, gap_q != 11'h7FF};
			quiet_q <= (moved || wr) ? 10'h000 : quiet_q + {9'h000, quiet_q != 10'h3FF};
		end
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered next cycle");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_dat_quiet: assert property (wb_dat_o[31:16] == 16'h0000 && (wb_ack_o || wb_dat_o == 32'h0))
		else $error("read data outside ack");
	a_pins_off: assert property (!en_q |-> !sck_oe_o && !sdo_oe_o && !ss_oe_o)
		else $error("pin driven while disabled");
	a_sdo_drive: assert property (en_q |-> sdo_oe_o == !c1_q[11])
		else $error("data out enable wrong");
	a_sck_drive: assert property (en_q |-> sck_oe_o == (c1_q[5] && !c1_q[12]))
		else $error("clock pin enable wrong");
	a_sck_rate: assert property (en_q && c1_q[5] && sck_oe_o && moved |-> gap_q >= div)
		else $error("serial clock faster than divider");
	a_sck_idle: assert property (en_q && c1_q[5] && quiet_q == 10'h3FF |-> sck_o == c1_q[6])
		else $error("serial clock idle level wrong");
	a_pulse_std: assert property (!enh_q && buf_cond_o |=> !buf_cond_o)
		else $error("standard mode event not a pulse");
	c_overflow: cover property (wb_ack_o && wb_dat_o[6]);
	c_fifo_cond: cover property (enh_q && buf_cond_o);
	c_idle_high: cover property (en_q && quiet_q == 10'h3FF && c1_q[6]);
endmodule : spf_port_checker

bind spf_port spf_port_checker u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.idle_mode_i(idle_mode_i), .buf_cond_o(buf_cond_o), .sck_i(sck_i), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
	.sdi_i(sdi_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .ss_i(ss_i), .ss_o(ss_o), .ss_oe_o(ss_oe_o)
);

// ===== dv/spf_peer.sv
// behavioural far-side peripheral shifting one word in and out per frame
`timescale 1ns/1ps
module spf_peer (
	// control from the bench
	input wire logic        en_i,
	input wire logic        cpol_i,
	input wire logic [15:0] tx_i,
	// serial pins
	input wire logic        sck_i,
	input wire logic        sdo_i,
	output logic            sdi_o,
	output logic [15:0]     rx_o
);
	logic [15:0] sh = 16'h0000;
	logic        rel = 1'b0;
	initial rx_o = 16'h0000;
	// load on select; recirculating inverted makes back-to-back words differ
	always @(posedge en_i) sh = tx_i;
	// a released line shows the inverse of its last bit
	always @(negedge en_i) rel = ~sh[15];
	// capture on the leading edge, present the next bit on the trailing edge
	always @(sck_i) begin
		if (en_i && sck_i != cpol_i) rx_o = {rx_o[14:0], sdo_i};
		if (en_i && sck_i == cpol_i) sh = {sh[14:0], ~sh[15]};
	end
	assign sdi_o = en_i ? sh[15] : rel;
endmodule : spf_peer

// ===== dv/spf_port_tb.sv
// self-checking bench: wishbone register tasks and serial transfers against a peer
`timescale 1ns/1ps
`include "spf_map.svh"
module spf_port_tb;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc   = 1'b0;
	logic        stb   = 1'b0;
	logic        we    = 1'b0;
	logic [3:0]  adr   = 4'h0;
	logic [31:0] wdat  = 32'h00000000;
	logic [31:0] rdat;
	logic        ack;
	logic        idl   = 1'b0;
	logic        cond;
	logic        sck;
	logic        sck_oe;
	logic        sdo;
	logic        sdo_oe;
	logic        ss;
	logic        ss_oe;
	logic        sdi;
	logic        sck_w;
	logic        pen   = 1'b0;
	logic        pol   = 1'b0;
	logic [15:0] ptx   = 16'h0000;
	logic [15:0] prx;
	logic [15:0] q;
	logic        sck_d = 1'b0;
	logic        ss_d  = 1'b1;
	int          fsn = 0;
	int          num_errors = 0;
	int          comparisons = 0;
	int          tog = 0;
	int          cyc_n = 0;
	int          t0;
	int          tt [0:1023];
	always #4 clk_i = ~clk_i;
	assign sck_w = sck_oe ? sck : 1'b0;
	spf_port u_dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .idle_mode_i(idl),
		.buf_cond_o(cond), .sck_i(sck_w), .sck_o(sck), .sck_oe_o(sck_oe), .sdi_i(sdi), .sdo_o(sdo),
		.sdo_oe_o(sdo_oe), .ss_i(ss_oe ? ss : 1'b1), .ss_o(ss), .ss_oe_o(ss_oe)
	);
	spf_peer u_peer (
		.en_i(pen), .cpol_i(pol), .tx_i(ptx), .sck_i(sck_w), .sdo_i(sdo_oe ? sdo : 1'b1), .sdi_o(sdi),
		.rx_o(prx)
	);
	// time stamps of every clock pin change, and a count of driven active-high sync pulses
	always @(posedge clk_i) begin
		cyc_n++;
		if (sck !== sck_d) begin
			tt[tog] = cyc_n;
			tog++;
		end
		sck_d = sck;
		if (ss_oe && ss === 1'b1 && ss_d === 1'b0) fsn++;
		ss_d = ss;
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [1:0] a, input logic [15:0] d, output logic [15:0] r);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {a, 2'h0};
		wdat <= {16'h0000, d};
		@(posedge clk_i);
		while (ack !== 1'b1 && n < 20) begin
			@(posedge clk_i);
			n++;
		end
		if (n == 20) chk("ack", 16'h0001, 16'h0000);
		r = rdat[15:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	endtask : bus
	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rc(input string nm, input logic [1:0] a, input logic [15:0] e);
		bus(1'b0, a, 16'h0000, q);
		chk(nm, e, q);
	endtask : rc
	task automatic wait_stat(input logic [15:0] m);
		int n;
		n = 0;
		bus(1'b0, `SPF_OFF_STAT, 16'h0000, q);
		while ((q & m) !== m && n < 1000) begin
			bus(1'b0, `SPF_OFF_STAT, 16'h0000, q);
			n++;
		end
		if (n == 1000) chk("status wait", m, q & m);
	endtask : wait_stat
	task automatic mode(input logic [2:0] c, input logic e);
		wr(`SPF_OFF_STAT, {11'h400, c, 2'h0});
		@(posedge clk_i);
		chk("buf_cond", {15'h0000, e}, {15'h0000, cond});
	endtask : mode
	task automatic stop_test;
		if (num_errors == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : stop_test
	initial begin
		repeat (20000) @(posedge clk_i);
		num_errors++;
		stop_test();
	end
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rc("stat", `SPF_OFF_STAT, `SPF_RESET_VAL);
		rc("con1", `SPF_OFF_CON1, `SPF_RESET_VAL);
		rc("con2", `SPF_OFF_CON2, `SPF_RESET_VAL);
		wr(`SPF_OFF_CON1, 16'hFFFF);
		rc("con1", `SPF_OFF_CON1, `SPF_CON1_WMASK);
		wr(`SPF_OFF_CON2, 16'hFFFF);
		rc("con2", `SPF_OFF_CON2, `SPF_CON2_WMASK);
		wr(`SPF_OFF_CON2, 16'h0000);
		wr(`SPF_OFF_STAT, 16'hFFFF);
		rc("stat", `SPF_OFF_STAT, `SPF_STAT_WMASK);
		wr(`SPF_OFF_STAT, 16'h0000);
		// master, 16 bit, data changes on the trailing edge, clock over 4
		wr(`SPF_OFF_CON1, 16'h053E);
		ptx <= 16'hC3A5;
		pen <= 1'b1;
		wr(`SPF_OFF_STAT, 16'h8000);
		t0 = tog;
		wr(`SPF_OFF_BUF, 16'h5A3C);
		wait_stat(16'h0001);
		chk("sck edges", 16'd32, 16'(tog - t0));
		chk("sck span", 16'd124, 16'(tt[t0 + 31] - tt[t0]));
		rc("rx word", `SPF_OFF_BUF, 16'hC3A5);
		chk("peer word", 16'h5A3C, prx);
		rc("stat", `SPF_OFF_STAT, 16'h8000);
		wr(`SPF_OFF_BUF, 16'h0F0F);
		wait_stat(16'h0001);
		wr(`SPF_OFF_BUF, 16'hF0F0);
		wait_stat(16'h0040);
		rc("stat", `SPF_OFF_STAT, 16'h8041);
		rc("rx word", `SPF_OFF_BUF, 16'h3C5A);
		wr(`SPF_OFF_STAT, 16'h8000);
		rc("stat", `SPF_OFF_STAT, 16'h8000);
		// 8 bit, clock idling high, held by idle mode first
		pen <= 1'b0;
		wr(`SPF_OFF_STAT, 16'h0000);
		wr(`SPF_OFF_CON1, 16'h017E);
		pol <= 1'b1;
		ptx <= 16'h9600;
		wr(`SPF_OFF_STAT, 16'hA000);
		// the clock pin settles to its high idle level after enable; let that edge be counted first
		@(posedge clk_i);
		idl <= 1'b1;
		pen <= 1'b1;
		t0 = tog;
		wr(`SPF_OFF_BUF, 16'h0069);
		repeat (200) @(posedge clk_i);
		chk("sck edges", 16'd0, 16'(tog - t0));
		idl <= 1'b0;
		wait_stat(16'h0001);
		chk("sck edges", 16'd16, 16'(tog - t0));
		rc("rx byte", `SPF_OFF_BUF, 16'h0096);
		chk("peer byte", 16'h0069, {8'h00, prx[7:0]});
		repeat (1100) @(posedge clk_i);
		// enhanced buffers: ten writes, nine fit, nine arrive, eight kept
		pen <= 1'b0;
		wr(`SPF_OFF_STAT, 16'h0000);
		wr(`SPF_OFF_CON1, 16'h053E);
		wr(`SPF_OFF_CON2, 16'h0001);
		pol <= 1'b0;
		ptx <= 16'h1234;
		pen <= 1'b1;
		wr(`SPF_OFF_STAT, 16'h800C);
		t0 = tog;
		for (int i = 0; i < 10; i++) wr(`SPF_OFF_BUF, 16'h00A0 + 16'(i));
		bus(1'b0, `SPF_OFF_STAT, 16'h0000, q);
		chk("tx full", 16'h0002, q & 16'h0002);
		wait_stat(16'h00C0);
		rc("stat", `SPF_OFF_STAT, 16'h80CD);
		chk("sck edges", 16'd288, 16'(tog - t0));
		chk("buf_cond", 16'h0001, {15'h0000, cond});
		for (int i = 0; i < 8; i++) begin
			rc("fifo word", `SPF_OFF_BUF, i[0] ? 16'hEDCB : 16'h1234);
			if (i == 0) begin
				mode(3'b011, 1'b0);
				mode(3'b010, 1'b1);
			end
			if (i == 2) begin
				mode(3'b010, 1'b0);
				mode(3'b001, 1'b1);
			end
		end
		mode(3'b001, 1'b0);
		mode(3'b000, 1'b1);
		rc("stat", `SPF_OFF_STAT, 16'h80A0);
		for (int k = 7; k >= 4; k--) mode(3'(k), k < 6);
		// last entry moved into the shift register leaves the transmit fifo empty while shifting
		mode(3'b110, 1'b0);
		wr(`SPF_OFF_BUF, 16'h00C3);
		@(posedge clk_i);
		chk("buf_cond", 16'h0001, {15'h0000, cond});
		// framed master, sync pulse out, active high, one bit clock ahead; edge bit kept clear
		wr(`SPF_OFF_STAT, 16'h0000);
		wr(`SPF_OFF_CON1, 16'h043E);
		wr(`SPF_OFF_CON2, 16'hA000);
		wr(`SPF_OFF_STAT, 16'h8000);
		chk("ss_oe", 16'h0001, {15'h0000, ss_oe});
		chk("ss idle", 16'h0000, {15'h0000, ss});
		t0 = fsn;
		wr(`SPF_OFF_BUF, 16'h00A5);
		wait_stat(16'h0001);
		chk("sync pulses", 16'h0001, 16'(fsn - t0));
		stop_test();
	end
endmodule : spf_port_tb
